// ---- light_prox_pkg.sv ----
// Constants for the sensor register bank: register offsets, field positions,
// reset values, serial-bus command layout, controller states and drive tables.
// Assumes a single 100 MHz clock domain inside the sensor.
package light_prox_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [4:0] ANALOG_CONTROL_ADDR = 5'h0F;
	localparam logic [4:0] PART_IDENT_ADDR = 5'h12;
	localparam logic [4:0] DEVICE_STATUS_ADDR = 5'h13;
	localparam logic [4:0] LIGHT_CH0_LOW_ADDR = 5'h14;
	localparam logic [4:0] LIGHT_CH0_HIGH_ADDR = 5'h15;
	localparam logic [4:0] LIGHT_CH1_LOW_ADDR = 5'h16;
	localparam logic [4:0] LIGHT_CH1_HIGH_ADDR = 5'h17;
	localparam logic [4:0] PROX_RESULT_LOW_ADDR = 5'h18;
	localparam logic [4:0] PROX_RESULT_HIGH_ADDR = 5'h19;
	localparam logic [4:0] PROX_OFFSET_COMP_ADDR = 5'h1E;
	localparam int RESULT_CHANNELS = 3;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int DRIVE_MSB = 7;
	localparam int DRIVE_LSB = 6;
	localparam int DIODE_MSB = 5;
	localparam int DIODE_LSB = 4;
	localparam int PROX_GAIN_MSB = 3;
	localparam int PROX_GAIN_LSB = 2;
	localparam int LGAIN_MSB = 1;
	localparam int LGAIN_LSB = 0;
	localparam int STAT_SATURATED_BIT = 6;
	localparam int STAT_PIRQ_BIT = 5;
	localparam int STAT_LIRQ_BIT = 4;
	localparam int STAT_PROX_VALID_BIT = 1;
	localparam int STAT_LVALID_BIT = 0;
	localparam int OFFSET_SIGN_BIT = 7;
	localparam logic [1:0] DIODE_RESERVED = 2'h3;
	localparam logic [7:0] ANALOG_CONTROL_RESET = 8'h00;
	localparam logic [7:0] PROX_OFFSET_RESET = 8'h00;

	// ------------------------------------------------------------
	// Command byte layout: bits 4:0 pointer, bits 6:5 transfer type
	// ------------------------------------------------------------
	localparam int CMD_TYPE_MSB = 6;
	localparam int CMD_TYPE_LSB = 5;
	localparam logic [1:0] CMD_TYPE_AUTO_INC = 2'h1;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	// ------------------------------------------------------------
	// LED sink current in tenths of a milliamp, per drive code
	// ------------------------------------------------------------
	localparam logic [10:0] LED_NORMAL_00 = 11'h4B0; // 120 mA
	localparam logic [10:0] LED_NORMAL_01 = 11'h258; // 60 mA
	localparam logic [10:0] LED_NORMAL_10 = 11'h12C; // 30 mA
	localparam logic [10:0] LED_NORMAL_11 = 11'h096; // 15 mA
	localparam logic [10:0] LED_REDUCED_00 = 11'h096; // 15 mA
	localparam logic [10:0] LED_REDUCED_01 = 11'h04B; // 7.5 mA
	localparam logic [10:0] LED_REDUCED_10 = 11'h026; // 3.8 mA
	localparam logic [10:0] LED_REDUCED_11 = 11'h013; // 1.9 mA
	localparam int REDUCED_SHIFT = 3;

	// ------------------------------------------------------------
	// Serial controller states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_CMD = 4'b0011,
		ST_CMD_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RDATA_ACK = 4'b1000
	} bus_state_e;

endpackage : light_prox_pkg

// ---- light_prox_sensor_regs.sv ----
// Register bank of a light and proximity sensor behind a two-wire serial bus.
// Assumes the measurement engine runs on clk_in and hands over results,
// completion pulses and flags as same-clock signals; bus pins are asynchronous.
//
// Function
// R01: Drive code 00..11 selects 120/60/30/15 mA, or 15/7.5/3.8/1.9 mA reduced.
// R02: Control byte holds drive, diode select, proximity gain and light gain fields.
// R03: Diode select picks none, first or second photodiode; code 11 is reserved.
// R04: Identification register returns a fixed part code; writes never change it.
// R05: Status register is read-only; host writes leave every flag untouched.
// R06: Status bit 6 sets when a proximity measurement saturated the front end.
// R07: Status bit 5 reads one while the proximity interrupt is asserted.
// R08: Status bit 4 reads one while the light interrupt is asserted.
// R09: Status bits 7, 3 and 2 always read as zero.
// R10: Status bit 1 sets once proximity integration completes after enable.
// R11: Status bit 0 sets once light integration completes after enable.
// R12: Two 16-bit light results sit at 0x14..0x17, low byte first.
// R13: Reading a light low byte copies its high byte into a shadow.
// R14: The shadowed high byte stays coherent despite later integration cycles.
// R15: Host should read each result as one auto-increment two-byte transfer.
// R16: Proximity result low byte sits at 0x18, high byte at 0x19.
// R17: Reading proximity low byte latches the high byte for the next read.
// R18: Offset is sign-magnitude; bit 7 zero shifts negative, one positive.
// R19: Proximity offset register holds zero after reset.
// R20: Offset shift scales with proximity gain, drive strength and pulse count.
// R21: Reduced-drive flag lowers the LED current for every drive code.
// R22: An 8-bit pulse count sets LED pulses per proximity accumulation.
// R23: Writes to read-only registers are acknowledged but change nothing.
`timescale 1ns/1ps

module light_prox_sensor_regs
	import light_prox_pkg::*;
#(
	parameter logic [6:0] BUS_ADDRESS = 7'h52, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'hA5 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Serial bus pins, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// Measurement engine results
	input wire logic [15:0] light_ch0_data_in,
	input wire logic [15:0] light_ch1_data_in,
	input wire logic [15:0] prox_data_in,
	input wire logic light_done_in,
	input wire logic prox_done_in,
	input wire logic prox_saturated_in,
	input wire logic prox_irq_in,
	input wire logic light_irq_in,
	// Settings held elsewhere in the device
	input wire logic prox_enable_bit_in,
	input wire logic light_enable_bit_in,
	input wire logic reduced_drive_flag_in,
	input wire logic [7:0] led_pulse_count_in,
	// Analog settings
	output logic [1:0] led_drive_strength_out,
	output logic [1:0] sense_diode_select_out,
	output logic [1:0] prox_gain_sel_out,
	output logic [1:0] light_gain_sel_out,
	output logic [10:0] led_current_out,
	output logic prox_offset_sign_out,
	output logic [21:0] prox_offset_shift_out
);

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic scl_meta_r;
	logic scl_sync_r;
	logic scl_prev_r;
	logic sda_meta_r;
	logic sda_sync_r;
	logic sda_prev_r;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// Three flops per pin; only the second stage and later feed logic
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_meta_r <= 1'b1;
			scl_sync_r <= 1'b1;
			scl_prev_r <= 1'b1;
			sda_meta_r <= 1'b1;
			sda_sync_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_meta_r <= scl_in;
			scl_sync_r <= scl_meta_r;
			scl_prev_r <= scl_sync_r;
			sda_meta_r <= sda_in;
			sda_sync_r <= sda_meta_r;
			sda_prev_r <= sda_sync_r;
		end
	end

	// Start and stop are data edges while the clock line is high
	assign scl_rise = scl_sync_r && !scl_prev_r;
	assign scl_fall = !scl_sync_r && scl_prev_r;
	assign bus_start = scl_sync_r && scl_prev_r && sda_prev_r && !sda_sync_r;
	assign bus_stop = scl_sync_r && scl_prev_r && !sda_prev_r && sda_sync_r;

	// ------------------------------------------------------------
	// Serial controller
	// ------------------------------------------------------------
	bus_state_e state_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [3:0] bit_cnt_r;
	logic [4:0] ptr_r;
	logic auto_inc_r;
	logic rw_r;
	logic master_nack_r;
	logic sda_oe_n_r;
	logic sda_out_r;
	logic [7:0] rd_byte;
	logic rd_load;
	logic wr_strobe;

	// A byte is fetched when the address is acknowledged for a read,
	// or when the host acknowledges the previous byte
	assign rd_load = scl_fall && ((state_r == ST_ADDR_ACK && rw_r) ||
		(state_r == ST_RDATA_ACK && !master_nack_r));
	assign wr_strobe = scl_fall && state_r == ST_WDATA && bit_cnt_r == BITS_PER_BYTE;

	// State, shifters and the open-drain data driver
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r <= ST_IDLE;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			rw_r <= 1'b0;
			master_nack_r <= 1'b0;
			sda_oe_n_r <= 1'b1;
		end else if (bus_start) begin
			state_r <= ST_ADDR; // Repeated start restarts from any state
			bit_cnt_r <= 4'h0;
			sda_oe_n_r <= 1'b1;
		end else if (bus_stop) begin
			state_r <= ST_IDLE;
			sda_oe_n_r <= 1'b1;
		end else if (scl_rise) begin
			if (state_r == ST_ADDR || state_r == ST_CMD || state_r == ST_WDATA) begin
				shift_r <= {shift_r[6:0], sda_sync_r};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end else if (state_r == ST_RDATA_ACK) begin
				master_nack_r <= sda_sync_r;
			end
		end else if (scl_fall) begin
			case (state_r)
				ST_ADDR: begin
					if (bit_cnt_r == BITS_PER_BYTE) begin
						if (shift_r[7:1] == BUS_ADDRESS) begin
							state_r <= ST_ADDR_ACK;
							rw_r <= shift_r[0];
							sda_oe_n_r <= 1'b0;
						end else begin
							state_r <= ST_IDLE; // Not ours: stay off the bus
						end
					end
				end
				ST_CMD: begin
					if (bit_cnt_r == BITS_PER_BYTE) begin
						state_r <= ST_CMD_ACK;
						sda_oe_n_r <= 1'b0;
					end
				end
				// R23 ack read-only writes
				ST_WDATA: begin
					if (bit_cnt_r == BITS_PER_BYTE) begin
						state_r <= ST_WDATA_ACK;
						sda_oe_n_r <= 1'b0;
					end
				end
				ST_CMD_ACK, ST_WDATA_ACK: begin
					state_r <= ST_WDATA;
					bit_cnt_r <= 4'h0;
					sda_oe_n_r <= 1'b1;
				end
				ST_ADDR_ACK, ST_RDATA_ACK: begin
					if (state_r == ST_ADDR_ACK && !rw_r) begin
						state_r <= ST_CMD;
						bit_cnt_r <= 4'h0;
						sda_oe_n_r <= 1'b1;
					end else if (state_r == ST_RDATA_ACK && master_nack_r) begin
						state_r <= ST_IDLE; // Host ends the read
						sda_oe_n_r <= 1'b1;
					end else begin
						state_r <= ST_RDATA;
						tx_r <= rd_byte;
						bit_cnt_r <= 4'h0;
						sda_oe_n_r <= rd_byte[7]; // Release for one, pull for zero
					end
				end
				ST_RDATA: begin
					if (bit_cnt_r == LAST_TX_BIT) begin
						state_r <= ST_RDATA_ACK;
						sda_oe_n_r <= 1'b1;
					end else begin
						tx_r <= {tx_r[6:0], 1'b0};
						sda_oe_n_r <= tx_r[6];
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// The pin only ever pulls low; the level driven is constant
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sda_out_r <= 1'b0;
		end else begin
			sda_out_r <= 1'b0;
		end
	end

	// Register pointer from the command byte, then auto-increment per byte
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ptr_r <= 5'h00;
			auto_inc_r <= 1'b0;
		end else if (scl_fall && state_r == ST_CMD && bit_cnt_r == BITS_PER_BYTE) begin
			ptr_r <= shift_r[4:0];
			auto_inc_r <= shift_r[CMD_TYPE_MSB:CMD_TYPE_LSB] == CMD_TYPE_AUTO_INC;
		end else if ((rd_load || wr_strobe) && auto_inc_r) begin
			ptr_r <= ptr_r + 5'h01;
		end
	end

	assign sda_out = sda_out_r;
	assign sda_oe_n_out = sda_oe_n_r;

	// ------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------
	logic [7:0] analog_control_r;
	logic [7:0] prox_offset_comp_r;

	// R02 control fields
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			analog_control_r <= ANALOG_CONTROL_RESET;
		end else if (wr_strobe && ptr_r == ANALOG_CONTROL_ADDR) begin
			analog_control_r[DRIVE_MSB:DRIVE_LSB] <= shift_r[DRIVE_MSB:DRIVE_LSB];
			analog_control_r[PROX_GAIN_MSB:LGAIN_LSB] <= shift_r[PROX_GAIN_MSB:LGAIN_LSB];
			// R03 reserved diode code
			if (shift_r[DIODE_MSB:DIODE_LSB] != DIODE_RESERVED) begin
				analog_control_r[DIODE_MSB:DIODE_LSB] <= shift_r[DIODE_MSB:DIODE_LSB];
			end
		end
	end

	// R19 offset cleared at reset
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prox_offset_comp_r <= PROX_OFFSET_RESET;
		end else if (wr_strobe && ptr_r == PROX_OFFSET_COMP_ADDR) begin
			prox_offset_comp_r <= shift_r;
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	logic prox_saturated_flag_r;
	logic prox_irq_flag_r;
	logic light_irq_flag_r;
	logic prox_result_valid_r;
	logic light_result_valid_r;
	logic [7:0] status_byte;

	// R06 saturation follows the latest proximity cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prox_saturated_flag_r <= 1'b0;
		end else if (prox_done_in) begin
			prox_saturated_flag_r <= prox_saturated_in;
		end
	end

	// R07 R08 interrupt levels mirrored
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prox_irq_flag_r <= 1'b0;
			light_irq_flag_r <= 1'b0;
		end else begin
			prox_irq_flag_r <= prox_irq_in;
			light_irq_flag_r <= light_irq_in;
		end
	end

	// R10 R11 valid after enabled cycle; a completion while disabled still clears valid
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prox_result_valid_r <= 1'b0;
			light_result_valid_r <= 1'b0;
		end else begin
			if (prox_done_in && prox_enable_bit_in) begin
				prox_result_valid_r <= 1'b1;
			end else if (!prox_enable_bit_in) begin
				prox_result_valid_r <= 1'b0;
			end
			if (light_done_in && light_enable_bit_in) begin
				light_result_valid_r <= 1'b1;
			end else if (!light_enable_bit_in) begin
				light_result_valid_r <= 1'b0;
			end
		end
	end

	// R09 reserved bits tied low; R05 no bus path writes these
	always_comb begin
		status_byte = 8'h00;
		status_byte[STAT_SATURATED_BIT] = prox_saturated_flag_r;
		status_byte[STAT_PIRQ_BIT] = prox_irq_flag_r;
		status_byte[STAT_LIRQ_BIT] = light_irq_flag_r;
		status_byte[STAT_PROX_VALID_BIT] = prox_result_valid_r;
		status_byte[STAT_LVALID_BIT] = light_result_valid_r;
	end

	// ------------------------------------------------------------
	// Result channels and high-byte shadows
	// ------------------------------------------------------------
	logic [15:0] chan_data [RESULT_CHANNELS];
	logic [7:0] shadow_r [RESULT_CHANNELS];

	assign chan_data[0] = light_ch0_data_in;
	assign chan_data[1] = light_ch1_data_in;
	assign chan_data[2] = prox_data_in;

	// R13 R14 R17 shadow capture on low-byte read only, so later cycles cannot tear it
	for (genvar g = 0; g < RESULT_CHANNELS; g++) begin : g_shadow
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				shadow_r[g] <= 8'h00;
			end else if (rd_load && ptr_r == LIGHT_CH0_LOW_ADDR + 5'(2 * g)) begin
				shadow_r[g] <= chan_data[g][15:8];
			end
		end
	end

	// R12 R16 read decode; R04 identification is a constant
	always_comb begin
		rd_byte = 8'h00; // Unmapped offsets read as zero
		if (ptr_r == ANALOG_CONTROL_ADDR) begin
			rd_byte = analog_control_r;
		end else if (ptr_r == PART_IDENT_ADDR) begin
			rd_byte = PART_CODE;
		end else if (ptr_r == DEVICE_STATUS_ADDR) begin
			rd_byte = status_byte;
		end else if (ptr_r == PROX_OFFSET_COMP_ADDR) begin
			rd_byte = prox_offset_comp_r;
		end else begin
			for (int i = 0; i < RESULT_CHANNELS; i++) begin
				if (ptr_r == LIGHT_CH0_LOW_ADDR + 5'(2 * i)) begin
					rd_byte = chan_data[i][7:0];
				end else if (ptr_r == LIGHT_CH0_HIGH_ADDR + 5'(2 * i)) begin
					rd_byte = shadow_r[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Analog outputs
	// ------------------------------------------------------------
	function automatic logic [10:0] led_current(input logic [1:0] code, input logic reduced);
		logic [10:0] ma;
		ma = 11'h000;
		case (code)
			2'h0: ma = reduced ? LED_REDUCED_00 : LED_NORMAL_00;
			2'h1: ma = reduced ? LED_REDUCED_01 : LED_NORMAL_01;
			2'h2: ma = reduced ? LED_REDUCED_10 : LED_NORMAL_10;
			default: ma = reduced ? LED_REDUCED_11 : LED_NORMAL_11;
		endcase
		return ma;
	endfunction : led_current

	logic [10:0] led_current_r;
	logic prox_offset_sign_r;
	logic [21:0] prox_offset_shift_r;
	logic [21:0] offset_scaled;

	// R20 R22 magnitude x 2^gain x pulses x drive ratio; only relative scale is modelled
	always_comb begin
		offset_scaled = 22'(prox_offset_comp_r[6:0]) * 22'(led_pulse_count_in);
		offset_scaled = offset_scaled << analog_control_r[PROX_GAIN_MSB:PROX_GAIN_LSB];
		offset_scaled = offset_scaled << (2'h3 - analog_control_r[DRIVE_MSB:DRIVE_LSB]);
		if (reduced_drive_flag_in) begin
			offset_scaled = offset_scaled >> REDUCED_SHIFT;
		end
	end

	// R01 R21 drive current; R18 sign passed on
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			led_current_r <= LED_NORMAL_00;
			prox_offset_sign_r <= 1'b0;
			prox_offset_shift_r <= 22'h000000;
		end else begin
			led_current_r <= led_current(analog_control_r[DRIVE_MSB:DRIVE_LSB],
				reduced_drive_flag_in);
			prox_offset_sign_r <= prox_offset_comp_r[OFFSET_SIGN_BIT];
			prox_offset_shift_r <= offset_scaled;
		end
	end

	assign led_drive_strength_out = analog_control_r[DRIVE_MSB:DRIVE_LSB];
	assign sense_diode_select_out = analog_control_r[DIODE_MSB:DIODE_LSB];
	assign prox_gain_sel_out = analog_control_r[PROX_GAIN_MSB:PROX_GAIN_LSB];
	assign light_gain_sel_out = analog_control_r[LGAIN_MSB:LGAIN_LSB];
	assign led_current_out = led_current_r;
	assign prox_offset_sign_out = prox_offset_sign_r;
	assign prox_offset_shift_out = prox_offset_shift_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_prox_low_read;
		rd_load && ptr_r == PROX_RESULT_LOW_ADDR;
	endsequence

	sequence s_ch0_low_read;
		rd_load && ptr_r == LIGHT_CH0_LOW_ADDR;
	endsequence

	a_ident_fixed: assert property (rd_load && ptr_r == PART_IDENT_ADDR |=> tx_r == PART_CODE) // R04
		else $error("identification byte not the part code");
	a_status_reserved: assert property (rd_load && ptr_r == DEVICE_STATUS_ADDR
		|=> tx_r[7] == 1'b0 && tx_r[3:2] == 2'h0) // R09
		else $error("reserved status bit read as one");
	a_prox_valid: assert property (prox_done_in && prox_enable_bit_in |=> prox_result_valid_r) // R10
		else $error("proximity valid not set after cycle");
	a_light_valid: assert property (light_done_in && light_enable_bit_in
		|=> status_byte[STAT_LVALID_BIT]) // R11
		else $error("light valid not set after cycle");
	a_prox_shadow: assert property (s_prox_low_read |=> shadow_r[2] == $past(prox_data_in[15:8])) // R17
		else $error("proximity shadow not captured");
	a_ch0_shadow_hold: assert property (s_ch0_low_read ##1 !rd_load [*2]
		|-> $stable(shadow_r[0])) // R14
		else $error("light shadow changed without a read");
	a_offset_reset: assert property (disable iff (1'b0) $past(rst_in) |-> prox_offset_comp_r == 8'h00) // R19
		else $error("offset not cleared by reset");
	a_diode_legal: assert property (sense_diode_select_out != DIODE_RESERVED) // R03
		else $error("reserved diode code stored");
	a_led_reduced: assert property (reduced_drive_flag_in && led_drive_strength_out == 2'h0
		|=> led_current_out == LED_REDUCED_00) // R21
		else $error("reduced drive current wrong");
	a_status_ro: assert property (wr_strobe && ptr_r == DEVICE_STATUS_ADDR && !prox_done_in
		&& prox_enable_bit_in |=> $stable(prox_result_valid_r)) // R05
		else $error("status changed by a host write");

endmodule : light_prox_sensor_regs

// ---- bus_host_model.sv ----
// Host model for the sensor's two-wire bus: start, stop, byte transfers,
// register write and paired register read. Assumes a pulled-up, resolved wire.
`timescale 1ns/1ps
module bus_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h52 // Arbitrary value
) (
	// Clock and resolved wire
	input wire logic clk_in,
	input wire logic sda_in,
	// Host drive, 1 = released
	output logic scl_out = 1'b1,
	output logic sda_out = 1'b1
);
	logic nak = 1'b0; // Set if any byte of the latest write went unanswered

	// Lines move just after an edge, so the sensor's synchroniser never races them
	task automatic tk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tk

	// One bit: data set in the low phase, wire read mid high phase
	task automatic bit_x(input logic b, output logic r);
		tk(4);
		sda_out = b;
		tk(4);
		scl_out = 1'b1;
		tk(4);
		r = sda_in;
		tk(4);
		scl_out = 1'b0;
	endtask : bit_x

	// Start or repeated start
	task automatic start();
		tk(4);
		sda_out = 1'b1;
		tk(4);
		scl_out = 1'b1;
		tk(8);
		sda_out = 1'b0;
		tk(8);
		scl_out = 1'b0;
	endtask : start

	// Stop, leaving both lines released
	task automatic stop();
		tk(4);
		sda_out = 1'b0;
		tk(4);
		scl_out = 1'b1;
		tk(8);
		sda_out = 1'b1;
		tk(8);
	endtask : stop

	// Eight bits MSB first, then the ninth: a is host drive, k the wire seen
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
			output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(a, k);
	endtask : xfer

	// Single register write, auto-increment command
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic k0, k1, k2;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, q, k0);
		xfer({3'b001, a}, 1'b1, q, k1);
		xfer(d, 1'b1, q, k2);
		stop();
		nak = k0 | k1 | k2;
	endtask : wr

	task automatic rd2(input logic [4:0] a, output logic [7:0] lo, output logic [7:0] hi);
		logic [7:0] q;
		logic k;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, q, k);
		xfer({3'b001, a}, 1'b1, q, k);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, q, k);
		xfer(8'hFF, 1'b0, lo, k);
		xfer(8'hFF, 1'b1, hi, k);
		stop();
	endtask : rd2
endmodule : bus_host_model

// ---- tb_top.sv ----
// Self-checking bench for the sensor register bank, driven over the bus.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/1ps
module tb_top;
	import light_prox_pkg::*;
	localparam logic [7:0] ID_CODE = 8'hA6; // Arbitrary value
	localparam logic [10:0] CUR_TAB [8] = '{LED_NORMAL_00, LED_NORMAL_01, LED_NORMAL_10,
		LED_NORMAL_11, LED_REDUCED_00, LED_REDUCED_01, LED_REDUCED_10, LED_REDUCED_11};
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic scl, hsda, dsda, oe_n, sda_w, osign;
	logic [15:0] d0 = 16'hA1B2, d1 = 16'hC3D4, dp = 16'hE5F6, e;
	logic pd = 1'b0, ld = 1'b0, prox_saturated_flag = 1'b0, pirq = 1'b0, lirq = 1'b0, red = 1'b0;
	logic prox_enable_bit = 1'b1, len = 1'b1;
	logic [7:0] pulses = 8'h04, lo, hi;
	logic [1:0] drv, dio, pg, lg;
	logic [10:0] cur;
	logic [21:0] osh;
	int error_cnt = 0, checks_done = 0, cyc = 0;

	// ----------------------------------------
	// Design, host and wire
	// ----------------------------------------
	light_prox_sensor_regs #(.BUS_ADDRESS(7'h52), .PART_CODE(ID_CODE)) dut_u (
		.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w), .sda_out(dsda),
		.sda_oe_n_out(oe_n), .light_ch0_data_in(d0), .light_ch1_data_in(d1),
		.prox_data_in(dp), .light_done_in(ld), .prox_done_in(pd), .prox_saturated_in(prox_saturated_flag),
		.prox_irq_in(pirq), .light_irq_in(lirq), .prox_enable_bit_in(prox_enable_bit),
		.light_enable_bit_in(len), .reduced_drive_flag_in(red), .led_pulse_count_in(pulses),
		.led_drive_strength_out(drv), .sense_diode_select_out(dio), .prox_gain_sel_out(pg),
		.light_gain_sel_out(lg), .led_current_out(cur), .prox_offset_sign_out(osign),
		.prox_offset_shift_out(osh));
	bus_host_model #(.DEV_ADDR(7'h52)) host_u (.clk_in(clk_in), .sda_in(sda_w),
		.scl_out(scl), .sda_out(hsda));
	// Open drain with pull-up: low if either side pulls
	assign sda_w = hsda & (oe_n | dsda);

	// Clock
	initial begin
		forever #5 clk_in = ~clk_in;
	end

	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic chk(input logic [21:0] g, input logic [21:0] x, input string m);
		checks_done++;
		if (g !== x) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
		end
	endtask : chk

	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	// One-cycle completion pulses on both channels
	task automatic pulse();
		@(posedge clk_in);
		#1 pd = 1'b1;
		ld = 1'b1;
		@(posedge clk_in);
		#1 pd = 1'b0;
		ld = 1'b0;
	endtask : pulse

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_control();
		logic [7:0] v;
		for (int k = 0; k < 8; k++) begin
			red = k[2];
			v = {k[1:0], 2'b10, k[1:0], ~k[1:0]};
			host_u.wr(ANALOG_CONTROL_ADDR, v);
			chk(22'({drv, dio, pg, lg}), 22'(v), "fields");
			chk(22'(cur), 22'(CUR_TAB[k]), "current");
			host_u.rd2(ANALOG_CONTROL_ADDR, lo, hi);
			chk(22'(lo), 22'(v), "control");
		end
		// Reserved diode code keeps the old diode field
		host_u.wr(ANALOG_CONTROL_ADDR, 8'h1B);
		host_u.wr(ANALOG_CONTROL_ADDR, 8'hF4);
		chk(22'({drv, dio, pg, lg}), 22'h0000D4, "diode");
	endtask : t_control

	task automatic t_ident_status();
		host_u.wr(PART_IDENT_ADDR, ~ID_CODE);
		chk(22'(host_u.nak), 22'h0, "ack");
		host_u.rd2(PART_IDENT_ADDR, lo, hi);
		chk(22'(lo), 22'(ID_CODE), "ident");
		{prox_saturated_flag, pirq, lirq} = 3'b101;
		pulse();
		host_u.wr(DEVICE_STATUS_ADDR, 8'h8C);
		host_u.rd2(DEVICE_STATUS_ADDR, lo, hi);
		chk(22'(lo), 22'h53, "status");
		{prox_saturated_flag, pirq, lirq} = 3'b010;
		pulse();
		host_u.rd2(DEVICE_STATUS_ADDR, lo, hi);
		chk(22'(lo), 22'h23, "status");
		// Disabled channels drop valid and ignore completions
		{prox_enable_bit, len} = 2'b00;
		pulse();
		host_u.rd2(DEVICE_STATUS_ADDR, lo, hi);
		chk(22'(lo), 22'h20, "disabled");
		{prox_enable_bit, len} = 2'b11;
		pulse();
		host_u.rd2(DEVICE_STATUS_ADDR, lo, hi);
		chk(22'(lo), 22'h23, "re-enabled");
	endtask : t_ident_status

	task automatic t_shadow();
		for (int i = 0; i < 3; i++) begin
			e = (i == 0) ? d0 : (i == 1) ? d1 : dp;
			host_u.rd2(LIGHT_CH0_LOW_ADDR + 5'(2 * i), lo, hi);
			chk(22'({hi, lo}), 22'(e), "result");
			{d0, d1, dp} = ~{d0, d1, dp};
			pulse();
			host_u.rd2(LIGHT_CH0_HIGH_ADDR + 5'(2 * i), lo, hi);
			chk(22'(lo), 22'(e[15:8]), "shadow");
		end
	endtask : t_shadow

	task automatic t_offset(input logic [7:0] v);
		red = 1'b0;
		host_u.wr(PROX_OFFSET_COMP_ADDR, v);
		chk({osign, osh[20:0]}, {v[7], 21'(v[6:0]) * 21'(pulses) * 21'h2}, "shift");
		// Reduced drive scales the shift down
		red = 1'b1;
		repeat (2) @(posedge clk_in);
		#1 chk(osh, 22'(v[6:0]) * 22'(pulses) * 22'h2 >> REDUCED_SHIFT, "reduced");
		red = 1'b0;
		host_u.rd2(PROX_OFFSET_COMP_ADDR, lo, hi);
		chk(22'(lo), 22'(v), "offset");
	endtask : t_offset

	// Cycle ceiling, well above the roughly 24k cycles of traffic
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt = error_cnt + 1;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_in);
		#1 rst_in = 1'b0;
		repeat (4) @(posedge clk_in);
		chk(22'(osign), 22'h0, "sign out");
		chk(osh, 22'h0, "shift out");
		host_u.rd2(PROX_OFFSET_COMP_ADDR, lo, hi);
		chk(22'(lo), 22'(PROX_OFFSET_RESET), "offset reset");
		t_control();
		t_ident_status();
		t_shadow();
		t_offset(8'h85);
		t_offset(8'h7F);
		end_of_test();
	end
endmodule : tb_top
